// ---- core/acs_top.sv ----
// Calibration sequencer top: power-up wait, request detect, run
`timescale 1ns/1ps
module acs_top
  import acs_pkg::*;
#(
  parameter logic [DLY_W-1:0] PU_WAIT_SHORT = PU_WAIT_SHORT_CYC,
  parameter logic [DLY_W-1:0] PU_WAIT_LONG  = PU_WAIT_LONG_CYC,
  parameter logic [RUN_W-1:0] RUN_TRIM      = RUN_TRIM_CYC,
  parameter logic [RUN_W-1:0] RUN_NOTRIM    = RUN_NOTRIM_CYC
)
(
  // Clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             rstn_i,
  // Control pins
  input  wire logic             cal_pin_i,
  input  wire logic             power_down_pin_i,
  input  wire logic             cal_delay_select_i,
  input  wire logic             trim_en_i,
  input  wire logic             phase_adj_en_i,
  input  wire logic             phase_cal_permit_bit_i,
  // Status
  output logic                  pwrup_wait_o,
  output logic                  cal_running_o,
  output logic                  cal_done_o,
  // Conversion data
  input  wire logic [DAT_W-1:0] sample_i,
  output logic      [DAT_W-1:0] data_o
);

  // Filter settle and idle cycles taken off the wait to meet its limit
  localparam logic [DLY_W-1:0] PU_OVH = DLY_W'(INIT_DONE) + 33'h2;

  typedef struct packed {
    acs_state_type     st;
    logic [IN_W-1:0]   s1;
    logic [IN_W-1:0]   s2;
    logic [IN_W-1:0]   s3;
    logic [IN_W-1:0]   flt;
    logic [2:0]        init;
    logic              blk;
    logic              pend;
    logic              trim;
    logic              done;
    logic [DLY_W-1:0]  dly;
    logic [RUN_W-1:0]  run;
    logic [CNT_W-1:0]  lo;
    logic [CNT_W-1:0]  hi;
  } acs_top_st_type;

  acs_top_st_type   q;
  acs_top_st_type   d;
  logic             req;
  logic [IN_W-1:0]  pins;
  logic             pd;
  logic             permit_ok;
  logic             init_ok;
  logic [DLY_W-1:0] wait_lim;
  logic [RUN_W-1:0] run_lim;

  ////////////////////////////////////////////////////////////////////////
  // Filtered pin view
  assign pins = {phase_cal_permit_bit_i, phase_adj_en_i, trim_en_i,
                 cal_delay_select_i, power_down_pin_i, cal_pin_i};
  assign pd        = q.flt[IN_PD];
  assign permit_ok = !q.flt[IN_PHADJ] || q.flt[IN_PERMIT];
  assign init_ok   = (q.init == INIT_DONE);
  assign wait_lim  = q.flt[IN_DSEL] ? PU_WAIT_LONG : PU_WAIT_SHORT;
  assign run_lim   = q.trim ? RUN_TRIM : RUN_NOTRIM;

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    d      = q;
    req    = 1'b0;
    d.done = 1'b0;
    // Three-stage sync, change taken when stages 2 and 3 agree
    d.s1  = pins;
    d.s2  = q.s1;
    d.s3  = q.s2;
    d.flt = (q.s2 & q.s3) | (q.flt & (q.s2 ^ q.s3));
    // Catch the request pin level once the filter has settled
    if (q.init == INIT_LAST)
    begin
      d.init = INIT_DONE;
      d.blk  = q.flt[IN_CAL];
    end
    else if (!init_ok)
    begin
      d.init = q.init + 3'h1;
    end
    // Request detect: low period, then high period
    if (init_ok)
    begin
      if (!q.flt[IN_CAL])
      begin
        d.hi = '0;
        // Low after a cut high phase starts a fresh low period
        if (q.hi != '0)
        begin
          d.lo = 11'h1;
        end
        else if (q.lo != CAL_MIN_CYC)
        begin
          d.lo = q.lo + 11'h1;
        end
      end
      else if (q.lo == CAL_MIN_CYC)
      begin
        if (q.hi == CAL_MIN_CYC - 11'h1)
        begin
          req  = 1'b1;
          d.lo = '0;
          d.hi = '0;
        end
        else
        begin
          d.hi = q.hi + 11'h1;
        end
      end
      else
      begin
        // Short low period: no credit carried to the next one
        d.hi = '0;
        d.lo = '0;
      end
    end
    // Sequencer
    case (q.st)
      ST_PWRUP:
      begin
        if (init_ok && !pd)
        begin
          if (q.dly >= wait_lim - PU_OVH)
          begin
            d.st   = ST_IDLE;
            d.pend = !q.blk;
          end
          else
          begin
            d.dly = q.dly + 33'h1;
          end
        end
      end
      ST_IDLE:
      begin
        if (q.pend && !pd)
        begin
          d.pend = 1'b0;
          if (permit_ok)
          begin
            d.st   = ST_RUN;
            d.run  = '0;
            d.trim = q.flt[IN_TRIM];
          end
        end
      end
      ST_RUN:
      begin
        if (pd)
        begin
          d.st   = ST_IDLE;
          d.pend = 1'b1;
        end
        else if (q.run >= run_lim - 21'h1)
        begin
          d.st   = ST_IDLE;
          d.done = 1'b1;
        end
        else
        begin
          d.run = q.run + 21'h1;
        end
      end
      default:
      begin
        d.st = ST_PWRUP;
      end
    endcase
    // A new request wins over any clear
    if (req)
    begin
      d.pend = 1'b1;
      d.blk  = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      q    <= '0;
      q.st <= ST_PWRUP;
    end
    else
    begin
      q <= d;
    end
  end

  // Status outputs
  assign pwrup_wait_o  = (q.st == ST_PWRUP);
  assign cal_running_o = (q.st == ST_RUN);
  assign cal_done_o    = q.done;

  ////////////////////////////////////////////////////////////////////////
  // Conversion pipeline
  acs_pipe_if pif ();

  assign pif.sample = sample_i;
  assign data_o     = pif.word;

  acs_pipe u_pipe (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .pif       (pif)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sequencer checks
  run_len_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    cal_done_o |-> $past(cal_running_o)
      && $past(q.run) == $past(run_lim) - 21'h1)
    else $error("calibration run length wrong");

  dly_lim_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    pwrup_wait_o |-> q.dly < wait_lim)
    else $error("power-up wait over limit");

  pd_gate_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    pwrup_wait_o && pd |=> $stable(q.dly))
    else $error("delay counter ran in power-down");

  blk_cal_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !cal_running_o && q.blk |=> !cal_running_o)
    else $error("calibration despite blocked request pin");

  pd_stop_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    pd |=> !cal_running_o)
    else $error("calibration in power-down");

  cal_permit_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    $rose(cal_running_o) |-> $past(permit_ok) && $past(q.pend))
    else $error("calibration started without permit");

endmodule : acs_top

// ---- core/acs_pkg.sv ----
// Constants, types and timing counts of the calibration sequencer
// Function
// - Calibration run ends within selected cycle limit
// - Power-up wait bounded by delay-select pin
// - New output word every input cycle
// - Pipeline latency is fixed whole cycles
// - Output delay added after pipeline latency
// - Power-down freezes power-up delay counter
// - Request high at power-up blocks calibration
// - No calibration start or run in power-down
// - Phase adjust needs permit bit to calibrate
package acs_pkg;

  // Synchronised pin vector positions
  localparam int IN_CAL    = 0;
  localparam int IN_PD     = 1;
  localparam int IN_DSEL   = 2;
  localparam int IN_TRIM   = 3;
  localparam int IN_PHADJ  = 4;
  localparam int IN_PERMIT = 5;
  localparam int IN_W      = 6;

  // Counter and data widths
  localparam int DLY_W = 33;
  localparam int RUN_W = 21;
  localparam int CNT_W = 11;
  localparam int DAT_W = 8;

  // Power-up wait limits in cycles
  localparam logic [DLY_W-1:0] PU_WAIT_SHORT_CYC = 33'h004000000;
  localparam logic [DLY_W-1:0] PU_WAIT_LONG_CYC  = 33'h100000000;

  // Calibration run lengths in cycles
  localparam logic [RUN_W-1:0] RUN_TRIM_CYC   = 21'h18b820;
  localparam logic [RUN_W-1:0] RUN_NOTRIM_CYC = 21'h149970;

  // Least low and high time of the request pin
  localparam logic [CNT_W-1:0] CAL_MIN_CYC = 11'h500;

  // Settling count of the pin filter after reset
  localparam logic [2:0] INIT_LAST = 3'h4;
  localparam logic [2:0] INIT_DONE = 3'h5;

  // Pipeline timing
  localparam int  PIPE_LAT_CYC = 13;
  localparam real CLK_PERIOD_NS = 25.0;
  localparam real OUT_DLY_NS    = 4.0;
  localparam int  OUT_DLY_CYC   =
    (int'($ceil(OUT_DLY_NS / CLK_PERIOD_NS)) < 1) ? 1 :
    int'($ceil(OUT_DLY_NS / CLK_PERIOD_NS));
  localparam int  PIPE_TOT_CYC  = PIPE_LAT_CYC + OUT_DLY_CYC;
  localparam logic [4:0] FILL_FULL = 5'(PIPE_TOT_CYC);

  // Sequencer states, Gray coded along the usual path
  typedef enum logic [1:0] {
    ST_PWRUP = 2'h0,
    ST_IDLE  = 2'h1,
    ST_RUN   = 2'h3
  } acs_state_type;

endpackage : acs_pkg

// ---- core/acs_pipe_if.sv ----
// Carrier between sequencer top and conversion pipeline
`timescale 1ns/1ps
interface acs_pipe_if;
  import acs_pkg::*;

  logic [DAT_W-1:0] sample;
  logic [DAT_W-1:0] drv;
  logic [DAT_W-1:0] word;

  modport top  (output sample, input  drv, input  word);
  modport pipe (input  sample, output drv, output word);
endinterface : acs_pipe_if

// ---- core/acs_pipe.sv ----
// Fixed-latency conversion pipeline with output delay stage
`timescale 1ns/1ps
module acs_pipe
  import acs_pkg::*;
(
  // Clock and reset
  input  wire logic  clk_sys_i,
  input  wire logic  rstn_i,
  // Data path
  acs_pipe_if.pipe   pif
);

  typedef struct packed {
    logic [PIPE_TOT_CYC-1:0][DAT_W-1:0] stg;
    logic [4:0]                         fill;
  } acs_pipe_st_type;

  acs_pipe_st_type q;
  acs_pipe_st_type d;

  ////////////////////////////////////////////////////////////////////////
  // Shift one word per cycle along the stages
  always_comb
  begin
    d = q;
    d.stg[0] = pif.sample;
    for (int i = 1; i < PIPE_TOT_CYC; i++)
    begin
      d.stg[i] = q.stg[i-1];
    end
    if (q.fill != FILL_FULL)
    begin
      d.fill = q.fill + 5'h1;
    end
  end

  // State register
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  // Word at driver stage, then after output delay
  assign pif.drv  = q.stg[PIPE_LAT_CYC-1];
  assign pif.word = q.stg[PIPE_TOT_CYC-1];

  ////////////////////////////////////////////////////////////////////////
  // Latency checks
  drv_lat_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    q.fill == FILL_FULL |-> pif.drv == $past(pif.sample, PIPE_LAT_CYC))
    else $error("driver stage latency wrong");

  out_lat_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    q.fill == FILL_FULL |-> pif.word == $past(pif.sample, PIPE_TOT_CYC))
    else $error("output word latency wrong");

  out_dly_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    q.fill == FILL_FULL |-> pif.word == $past(pif.drv, 1))
    else $error("output delay stage wrong");

endmodule : acs_pipe

// ---- verification/acs_host_model.sv ----
// Host model that drives the calibration request pin
`timescale 1ns/1ps
module acs_host_model
(
  // Clock
  input  wire logic        clk_sys_i,
  // Request control from the bench
  input  wire logic        go_i,
  input  wire logic [11:0] low_cyc_i,
  input  wire logic [11:0] high_cyc_i,
  // Pin and status
  output logic             cal_pin_o,
  output logic             busy_o
);
  // Low phase, then high phase; pin is left high afterwards
  initial
  begin
    cal_pin_o = 1'b0;
    busy_o    = 1'b0;
    forever
    begin
      @(posedge clk_sys_i iff go_i);
      #2;
      busy_o = 1'b1;
      cal_pin_o = 1'b0;
      repeat (low_cyc_i) @(posedge clk_sys_i);
      #2;
      cal_pin_o = 1'b1;
      repeat (high_cyc_i) @(posedge clk_sys_i);
      #2;
      busy_o = 1'b0;
    end
  end
endmodule : acs_host_model

// ---- verification/acs_top_tb.sv ----
// Self-checking bench of the calibration sequencer
`timescale 1ns/1ps
module acs_top_tb;
  import acs_pkg::*;
  localparam logic [31:0] RT = 32'h30;
  localparam logic [31:0] RN = 32'h20;
  logic             clk_sys_i = 1'b0;
  logic             rstn_i = 1'b0;
  logic             pd = 1'b0;
  logic             dsel = 1'b0;
  logic             trim = 1'b1;
  logic             phadj = 1'b0;
  logic             permit = 1'b0;
  logic             go = 1'b0;
  logic [11:0]      lo = 12'h500;
  logic [11:0]      hi = 12'h500;
  logic [DAT_W-1:0] smp = '0;
  logic [DAT_W-1:0] dout;
  logic             busy, cal_pin, pw, run, done;
  int               mismatches = 0;
  int               samples_checked = 0;
  int               cyc = 0;

  ////////////////////////////////////////////////////////////////////////
  // Clock, timeout and instances
  always #12.5 clk_sys_i = ~clk_sys_i;

  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      mismatches++;
      final_report();
    end
  end

  acs_host_model i_acs_host_model (.clk_sys_i(clk_sys_i), .go_i(go),
    .low_cyc_i(lo), .high_cyc_i(hi), .cal_pin_o(cal_pin), .busy_o(busy));

  acs_top #(.PU_WAIT_SHORT(33'h40), .PU_WAIT_LONG(33'h80),
    .RUN_TRIM(21'h30), .RUN_NOTRIM(21'h20)) i_acs_top (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .cal_pin_i(cal_pin),
    .power_down_pin_i(pd), .cal_delay_select_i(dsel), .trim_en_i(trim),
    .phase_adj_en_i(phadj), .phase_cal_permit_bit_i(permit),
    .pwrup_wait_o(pw), .cal_running_o(run), .cal_done_o(done),
    .sample_i(smp), .data_o(dout));

  ////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic final_report;
    if (mismatches == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] seen, exp, input string m);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #2;
  endtask : tick

  task automatic do_reset;
    rstn_i = 1'b0;
    tick(3);
    chk(32'(pw), 32'h1, "wait flag in reset");
    rstn_i = 1'b1;
  endtask : do_reset

  task automatic request;
    int n;
    n = 0;
    go = 1'b1;
    tick(1);
    go = 1'b0;
    tick(1);
    while (busy && n < 4000)
    begin
      tick(1);
      n++;
    end
  endtask : request

  // Run within 40 cycles, exact length, one-cycle done pulse
  task automatic run_len(input logic [31:0] exp);
    int n;
    n = 0;
    while (!run && n < 40)
    begin
      tick(1);
      n++;
    end
    n = 0;
    while (run && n < 4000)
    begin
      tick(1);
      n++;
    end
    chk(32'(n), exp, "run length");
    chk(32'(done), 32'h1, "done pulse missing");
    tick(1);
    chk(32'(done), 32'h0, "done pulse too long");
  endtask : run_len

  // Counts cycles the wait flag stays high, checks the window
  task automatic wait_len(input int lo_b, hi_b);
    int n;
    n = 0;
    while (pw && n < 400)
    begin
      tick(1);
      n++;
    end
    chk(32'(n >= lo_b && n <= hi_b), 32'h1, "power-up wait");
  endtask : wait_len

  // Counts run cycles over a quiet span; none expected
  task automatic no_run(input string m);
    int n;
    n = 0;
    repeat (100)
    begin
      tick(1);
      n += int'(run);
    end
    chk(32'(n), 32'h0, m);
  endtask : no_run

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_powerup;
    do_reset();
    wait_len(56, 64);
    run_len(RT);
  endtask : t_powerup

  task automatic t_pipe;
    logic [DAT_W-1:0] hist[$];
    for (int i = 0; i < 40; i++)
    begin
      tick(1);
      if (i >= 14)
        chk(32'(dout), 32'(hist[i-14]), "pipeline word");
      smp = DAT_W'(i * 7 + 3);
      hist.push_back(smp);
    end
  endtask : t_pipe

  task automatic t_request;
    trim = 1'b0;
    phadj = 1'b1;
    permit = 1'b1;
    request();
    run_len(RN);
    lo = 12'h3e8;
    request();
    no_run("short low accepted");
    lo = 12'h500;
    permit = 1'b0;
    request();
    no_run("run without permit");
  endtask : t_request

  task automatic t_pd;
    int n;
    n = 0;
    permit = 1'b1;
    request();
    tick(10);
    pd = 1'b1;
    while (run && n < 20)
    begin
      tick(1);
      n++;
    end
    chk(32'(n <= 8), 32'h1, "run kept in power-down");
    no_run("run in power-down");
    pd = 1'b0;
    run_len(RN);
  endtask : t_pd

  task automatic t_reset2;
    pd = 1'b1;
    dsel = 1'b1;
    do_reset();
    tick(300);
    chk(32'(pw), 32'h1, "wait ran in power-down");
    pd = 1'b0;
    wait_len(120, 128);
    no_run("run with pin high at power-up");
    request();
    run_len(RN);
  endtask : t_reset2

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    t_powerup();
    t_pipe();
    t_request();
    t_pd();
    t_reset2();
    final_report();
  end
endmodule : acs_top_tb
